// File: ckm_pkg.sv
// Package with register map, field positions, mode and strap codes and timing counts for the carkit mode block.
// Overview of operation
// [R01] ID grounded about 6 ms to exit audio
// [R02] Timed pulse bit grounds ID, self-clears
// [R03] Hold bit keeps ID grounded until cleared
// [R04] Dminus_pulse_request_bit 200-500 ns in audio, self-clears
// [R05] Accessory interrupts with 200-500 ns DP dip
// [R06] DP dip sets detector output and flag
// [R07] Detector enabled only in audio mode
// [R08] Accessory accepts 4-8 ms Id_timed_pulse_bit
// [R09] Power-up always in USB signalling mode
// [R10] Strap decoded into three default states
// [R11] Strap grounded: encoding 1, bidirectional 0
// [R12] Strap high: encoding 0, bidirectional 1
// [R13] Strap floating: both bits 1
// [R14] Power enable is pin AND control bit
// [R15] Enable pin forces pull-up and battery source
// [R16] Reset release latches defaults, enable 1 ms later
// [R17] Host later hands control to software
// [R18] Audio mode means mode code 100 or 101
// [R19] Pulses timed by counters at range centre
// [R20] Repeated pulse write does not restart pulse
package ckm_pkg;
    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_MODE   = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    // Control register fields.
    localparam int CTRL_ID_HOLD   = 0;
    localparam int CTRL_ID_TIMED_PULSE_BIT  = 1;
    localparam int CTRL_DMINUS_PULSE_REQUEST_BIT  = 2;
    localparam int CTRL_PWR       = 3;
    // Mode register fields.
    localparam int MODE_LSB       = 0;
    localparam int MODE_SE0_ENC   = 4;
    localparam int MODE_BIDIR     = 5;
    // Status register fields.
    localparam int STAT_IRQ       = 0;
    localparam int STAT_DET       = 1;
    localparam int STAT_ID_SW     = 2;
    localparam int STAT_XCVR_EN   = 3;
    // Signalling mode codes.
    localparam logic [2:0] MODE_USB    = 3'h0;
    localparam logic [2:0] MODE_MONO   = 3'h4;
    localparam logic [2:0] MODE_STEREO = 3'h5;
    // Strap encodings on the two-bit strap input.
    localparam logic [1:0] STRAP_GND   = 2'h0;
    localparam logic [1:0] STRAP_FLOAT = 2'h1;
    localparam logic [1:0] STRAP_HIGH  = 2'h2;
    // Timing.
    localparam longint CLK_HZ        = 40000000;
    localparam longint ID_TIMED_PULSE_BIT_US   = 6000;
    localparam longint DMINUS_PULSE_REQUEST_BIT_NS   = 350;
    localparam longint PWRUP_US      = 1000;
    localparam int     ID_TIMED_PULSE_BIT_CYC  = int'(ID_TIMED_PULSE_BIT_US * CLK_HZ / 1000000);
    localparam int     DMINUS_PULSE_REQUEST_BIT_CYC  = int'(DMINUS_PULSE_REQUEST_BIT_NS * CLK_HZ / 1000000000);
    localparam int     PWRUP_CYC     = int'(PWRUP_US * CLK_HZ / 1000000);
    localparam int     CNT_W         = 18;
    typedef enum logic [1:0] {PU_IDLE, PU_WAIT, PU_DONE} ckm_pu_t;
endpackage : ckm_pkg

// File: ckm_top.sv
// Carkit mode transition signalling and power-up control with an APB register slave.
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module ckm_top
    import ckm_pkg::*;
#(
    parameter int ID_CYC  = ID_TIMED_PULSE_BIT_CYC,
    parameter int PU_CYC  = PWRUP_CYC
)
(
    // Clock and reset.
    input  wire logic        SYS_CLK,
    input  wire logic        SRST,
    // APB slave.
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Device pins and analog controls.
    input  wire logic        ACTIVE_LOW_RESET_N,
    input  wire logic        ENABLE_PIN,
    input  wire logic [1:0]  BOOT_STRAP_PIN,
    input  wire logic        DP_BELOW_THRESH,
    output logic             ID_GROUND_SWITCH,
    output logic             DMINUS_PULSE_REQUEST_BIT_OUT,
    output logic             CARKIT_DET_OUT,
    output logic             CARKIT_IRQ_FLAG,
    output logic             XCVR_ENABLE,
    output logic             REG_ENABLE,
    output logic             DP_PULLUP_ON,
    output logic             REG_SRC_BATTERY,
    output logic      [2:0]  SIGNAL_MODE,
    output logic             SE0_ENCODING,
    output logic             BIDIRECTIONAL
);
    // Registers.
    logic             id_hold_low_bit;
    logic             id_timed_pulse_bit;
    logic             dminus_pulse_request_bit;
    logic             transceiver_power_ctrl_bit;
    logic [2:0]       mode;
    logic             enc_bit;
    logic             bidir_bit;
    logic             carkit_irq_flag;
    logic [CNT_W-1:0] id_cnt;
    logic [CNT_W-1:0] dm_cnt;
    logic [CNT_W-1:0] pu_cnt;
    logic             rst_n_q;
    logic             pu_enable;
    logic             id_done_q;
    logic             dm_done_q;
    ckm_pu_t          pu_state;

    // Decode of APB access.
    wire logic access  = PSEL & PENABLE;
    wire logic wr      = access & PWRITE;
    wire logic wr_ctrl = wr & (PADDR == ADDR_CTRL);
    wire logic wr_mode = wr & (PADDR == ADDR_MODE);
    wire logic wr_stat = wr & (PADDR == ADDR_STATUS);
    wire logic mapped  = (PADDR == ADDR_CTRL) | (PADDR == ADDR_MODE) | (PADDR == ADDR_STATUS);

    // Audio mode test shared by detector and Dminus_pulse_request_bit.
    function automatic logic is_audio(input logic [2:0] m);
        is_audio = (m == MODE_MONO) | (m == MODE_STEREO); // [R18]
    endfunction

    wire logic audio      = is_audio(mode);
    wire logic det_live   = audio & DP_BELOW_THRESH; // [R06] [R07]
    wire logic id_running = (id_cnt != '0);
    wire logic dm_running = (dm_cnt != '0);
    wire logic rst_rise   = ACTIVE_LOW_RESET_N & ~rst_n_q;
    wire logic pwr_en     = ENABLE_PIN & transceiver_power_ctrl_bit; // [R14]

    // Strap decoding into default encoding and direction bits.
    wire logic strap_enc = (BOOT_STRAP_PIN != STRAP_HIGH); // [R10] [R11] [R12] [R13]
    wire logic strap_bid = (BOOT_STRAP_PIN != STRAP_GND);  // [R10] [R11] [R12] [R13]

    // Pulse timers: ID at 6 ms, DM at 350 ns, both clocked by the logic clock.
    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
        begin
            id_cnt <= '0;
            dm_cnt <= '0;
        end
        else
        begin
            if (id_timed_pulse_bit & ~id_hold_low_bit & ~id_running & id_cnt == '0 & ~id_done_q)
                id_cnt <= CNT_W'(ID_CYC); // [R01] [R19]
            else if (id_running)
                id_cnt <= id_cnt - 1'b1;
            if (dminus_pulse_request_bit & audio & ~dm_running & ~dm_done_q)
                dm_cnt <= CNT_W'(DMINUS_PULSE_REQUEST_BIT_CYC); // [R04] [R19]
            else if (dm_running)
                dm_cnt <= dm_cnt - 1'b1;
        end
    end

    // One-cycle markers that a pulse has just ended, so the bit clears before restarting.
    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
        begin
            id_done_q <= 1'b0;
            dm_done_q <= 1'b0;
        end
        else
        begin
            id_done_q <= (id_cnt == CNT_W'(1));
            dm_done_q <= (dm_cnt == CNT_W'(1));
        end
    end

    // Control register; pulse bits self-clear at pulse end, writes during a pulse do not extend it.
    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
        begin
            id_hold_low_bit            <= 1'b0;
            id_timed_pulse_bit         <= 1'b0;
            dminus_pulse_request_bit   <= 1'b0;
            transceiver_power_ctrl_bit <= 1'b1; // [R14]
        end
        else
        begin
            if (wr_ctrl)
            begin
                id_hold_low_bit            <= PWDATA[CTRL_ID_HOLD]; // [R03]
                transceiver_power_ctrl_bit <= PWDATA[CTRL_PWR];
            end
            if (id_done_q)
                id_timed_pulse_bit <= 1'b0; // [R02]
            else if (wr_ctrl & ~id_running)
                id_timed_pulse_bit <= PWDATA[CTRL_ID_TIMED_PULSE_BIT]; // [R20]
            if (dm_done_q)
                dminus_pulse_request_bit <= 1'b0; // [R04]
            else if (wr_ctrl & ~dm_running)
                dminus_pulse_request_bit <= PWDATA[CTRL_DMINUS_PULSE_REQUEST_BIT];
        end
    end

    // Mode register; powers up in USB mode, strap defaults latched at reset release.
    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
        begin
            mode      <= MODE_USB; // [R09]
            enc_bit   <= 1'b1;
            bidir_bit <= 1'b0;
        end
        else if (rst_rise)
        begin
            mode      <= MODE_USB;  // [R09]
            enc_bit   <= strap_enc; // [R16]
            bidir_bit <= strap_bid; // [R16]
        end
        else if (wr_mode & ~ENABLE_PIN)
        begin
            mode      <= PWDATA[MODE_LSB +: 3]; // [R15]
            enc_bit   <= PWDATA[MODE_SE0_ENC];
            bidir_bit <= PWDATA[MODE_BIDIR];
        end
    end

    // Carkit flag: set wins over a write-one clear.
    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
            carkit_irq_flag <= 1'b0;
        else if (det_live)
            carkit_irq_flag <= 1'b1; // [R06]
        else if (wr_stat & PWDATA[STAT_IRQ])
            carkit_irq_flag <= 1'b0;
    end

    // Power-up sequencer: 1 ms after reset release the transceiver and regulator may turn on.
    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
        begin
            rst_n_q   <= 1'b0;
            pu_state  <= PU_IDLE;
            pu_cnt    <= '0;
            pu_enable <= 1'b0;
        end
        else
        begin
            rst_n_q <= ACTIVE_LOW_RESET_N;
            case (pu_state)
                PU_IDLE:
                begin
                    pu_enable <= 1'b0;
                    if (rst_rise)
                    begin
                        pu_cnt   <= CNT_W'(PU_CYC); // [R16]
                        pu_state <= PU_WAIT;
                    end
                end
                PU_WAIT:
                begin
                    if (~ACTIVE_LOW_RESET_N)
                        pu_state <= PU_IDLE;
                    else if (pu_cnt == CNT_W'(1))
                    begin
                        pu_enable <= 1'b1; // [R16]
                        pu_state  <= PU_DONE;
                    end
                    else
                        pu_cnt <= pu_cnt - 1'b1;
                end
                PU_DONE:
                begin
                    if (~ACTIVE_LOW_RESET_N)
                    begin
                        pu_enable <= 1'b0;
                        pu_state  <= PU_IDLE;
                    end
                end
                default:
                    pu_state <= PU_IDLE;
            endcase
        end
    end

    // Registered pin outputs.
    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
        begin
            ID_GROUND_SWITCH <= 1'b0;
            DMINUS_PULSE_REQUEST_BIT_OUT     <= 1'b0;
            CARKIT_DET_OUT   <= 1'b0;
            XCVR_ENABLE      <= 1'b0;
            REG_ENABLE       <= 1'b0;
            DP_PULLUP_ON     <= 1'b0;
            REG_SRC_BATTERY  <= 1'b0;
        end
        else
        begin
            ID_GROUND_SWITCH <= id_hold_low_bit | id_running; // [R02] [R03]
            DMINUS_PULSE_REQUEST_BIT_OUT     <= dm_running; // [R04]
            CARKIT_DET_OUT   <= det_live; // [R06]
            XCVR_ENABLE      <= pu_enable & pwr_en; // [R14] [R16]
            REG_ENABLE       <= pu_enable & pwr_en; // [R16]
            DP_PULLUP_ON     <= ENABLE_PIN; // [R15]
            REG_SRC_BATTERY  <= ENABLE_PIN; // [R15]
        end
    end

    // Read data mux.
    wire logic [31:0] rd_ctrl = {28'h000_0000, transceiver_power_ctrl_bit, dminus_pulse_request_bit,
                                 id_timed_pulse_bit, id_hold_low_bit};
    wire logic [31:0] rd_mode = {26'h000_0000, bidir_bit, enc_bit, 1'b0, mode};
    wire logic [31:0] rd_stat = {28'h000_0000, XCVR_ENABLE, ID_GROUND_SWITCH, CARKIT_DET_OUT, carkit_irq_flag};
    wire logic [31:0] rd_mux  = (PADDR == ADDR_CTRL) ? rd_ctrl :
                                (PADDR == ADDR_MODE) ? rd_mode :
                                (PADDR == ADDR_STATUS) ? rd_stat : 32'h0000_0000;

    // Read data register, captured in the setup cycle so it is valid in the access phase.
    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
            PRDATA <= 32'h0000_0000;
        else if (PSEL & ~PENABLE)
            PRDATA <= rd_mux;
    end

    assign PREADY          = 1'b1;
    assign PSLVERR         = access & ~mapped;
    assign CARKIT_IRQ_FLAG = carkit_irq_flag;
    assign SIGNAL_MODE     = mode;
    assign SE0_ENCODING    = enc_bit;
    assign BIDIRECTIONAL   = bidir_bit;
endmodule // ckm_top
`default_nettype wire

// File: ckm_props.sv
// Checker of the carkit mode block at its ports.
`timescale 1ns/1ps
`default_nettype none
module ckm_props
    import ckm_pkg::*;
#(
    parameter int ID_CYC = 20,
    parameter int PU_CYC = 10
)
(
    // Clock, reset and pins.
    input wire logic       SYS_CLK,
    input wire logic       SRST,
    input wire logic       ACTIVE_LOW_RESET_N,
    input wire logic       ENABLE_PIN,
    input wire logic [1:0] BOOT_STRAP_PIN,
    input wire logic       DP_BELOW_THRESH,
    // Outputs under watch.
    input wire logic       DMINUS_PULSE_REQUEST_BIT_OUT,
    input wire logic       CARKIT_DET_OUT,
    input wire logic       CARKIT_IRQ_FLAG,
    input wire logic       XCVR_ENABLE,
    input wire logic       REG_ENABLE,
    input wire logic       DP_PULLUP_ON,
    input wire logic       REG_SRC_BATTERY,
    input wire logic [2:0] SIGNAL_MODE,
    input wire logic       SE0_ENCODING,
    input wire logic       BIDIRECTIONAL
);
    wire         aud = SIGNAL_MODE[2:1] == 2'b10;
    logic [15:0] hi_cnt;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    // Counts cycles since the device reset pin was seen high.
    always_ff @(posedge SYS_CLK)
        if (SRST || !ACTIVE_LOW_RESET_N)
            hi_cnt <= 16'h0000;
        else if (hi_cnt != 16'hFFFF)
            hi_cnt <= hi_cnt + 16'h0001;
    // Relations between the pins that the block must keep.
    property p_dm_len; $rose(DMINUS_PULSE_REQUEST_BIT_OUT) |-> DMINUS_PULSE_REQUEST_BIT_OUT [*8] ##1 DMINUS_PULSE_REQUEST_BIT_OUT [*6] ##1 !DMINUS_PULSE_REQUEST_BIT_OUT; endproperty
    a_dm_len: assert property (p_dm_len) else $error("dminus_pulse_request_bit width wrong");
    property p_dm_aud; $rose(DMINUS_PULSE_REQUEST_BIT_OUT) |-> $past(aud); endproperty
    a_dm_aud: assert property (p_dm_aud) else $error("dminus_pulse_request_bit outside audio mode");
    property p_det_on; DP_BELOW_THRESH && aud |=> CARKIT_DET_OUT && CARKIT_IRQ_FLAG; endproperty
    a_det_on: assert property (p_det_on) else $error("dip in audio mode missed");
    property p_det_off; !aud |=> !CARKIT_DET_OUT && !$rose(CARKIT_IRQ_FLAG); endproperty
    a_det_off: assert property (p_det_off) else $error("detector active outside audio");
    property p_xcvr_and; XCVR_ENABLE |-> REG_ENABLE && $past(ENABLE_PIN); endproperty
    a_xcvr_and: assert property (p_xcvr_and) else $error("enable not gated by pin");
    property p_pullup; !$past(SRST) |-> DP_PULLUP_ON == $past(ENABLE_PIN) && REG_SRC_BATTERY == DP_PULLUP_ON; endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up or source not following pin");
    property p_xcvr_pu; $rose(XCVR_ENABLE) |-> hi_cnt >= PU_CYC + 2; endproperty
    a_xcvr_pu: assert property (p_xcvr_pu) else $error("transceiver enabled too early");
    property p_strap; $rose(ACTIVE_LOW_RESET_N) |=> ##1 SE0_ENCODING == (BOOT_STRAP_PIN != STRAP_HIGH)
        && BIDIRECTIONAL == (BOOT_STRAP_PIN != STRAP_GND) && SIGNAL_MODE == MODE_USB; endproperty
    a_strap: assert property (p_strap) else $error("strap defaults wrong");
endmodule // ckm_props
bind ckm_top ckm_props #(.ID_CYC(ID_CYC), .PU_CYC(PU_CYC)) u_props (.*);
`default_nettype wire

// File: ckm_acc_model.sv
// Accessory model: dips DP on request and measures ID and DM pulses.
`timescale 1ns/1ps
`default_nettype none
module ckm_acc_model (
    // Clock and observed lines.
    input  wire logic        clk,
    input  wire logic        id_sw,
    input  wire logic        dm,
    // Dip request from the bench.
    input  wire logic        dip_go,
    input  wire logic [4:0]  dip_len,
    // DP comparator level and measured widths.
    output logic             dp_low,
    output logic      [15:0] id_len,
    output logic      [15:0] dm_len
);
    logic [15:0] id_run = '0;
    logic [15:0] dm_run = '0;
    logic [4:0]  dip_cnt = '0;
    // DP stays below threshold for the requested number of cycles.
    assign dp_low = dip_cnt != 5'h00;
    // Each pulse width is kept when the pulse ends.
    always @(posedge clk)
    begin
        dip_cnt <= dip_go ? dip_len : dip_cnt - 5'(dip_cnt != 5'h00);
        id_run <= id_sw ? id_run + 16'h0001 : 16'h0000;
        dm_run <= dm ? dm_run + 16'h0001 : 16'h0000;
        if (!id_sw && id_run != 16'h0000)
            id_len <= id_run;
        if (!dm && dm_run != 16'h0000)
            dm_len <= dm_run;
    end
endmodule // ckm_acc_model
`default_nettype wire

// File: ckm_top_tb_top.sv
// Self-checking bench of the carkit mode and power-up block.
`timescale 1ns/1ps
`default_nettype none
module ckm_top_tb_top;
    import ckm_pkg::*;
    localparam int IDC = 20;
    localparam int PUC = 10;
    logic        clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, arst_n = 0, en = 1, dgo = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwd = '0, prd, rd, r, seed = 32'h0000_74A7;
    logic [1:0]  strap = '0;
    logic [4:0]  dlen = '0;
    logic [2:0]  mode, md;
    logic        pready, serr, idsw, dm, det, irq, xen, ren, pu, bat, se0, bid, dpl;
    logic [15:0] idl, dml;
    int          errors = 0, n_tests = 0;
    // System clock.
    always #12.5 clk = ~clk;
    // Block under test with short counts, and the accessory.
    ckm_top #(.ID_CYC(IDC), .PU_CYC(PUC)) DUT (.SYS_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd), .PRDATA(prd), .PREADY(pready), .PSLVERR(serr),
        .ACTIVE_LOW_RESET_N(arst_n), .ENABLE_PIN(en), .BOOT_STRAP_PIN(strap), .DP_BELOW_THRESH(dpl),
        .ID_GROUND_SWITCH(idsw), .DMINUS_PULSE_REQUEST_BIT_OUT(dm), .CARKIT_DET_OUT(det), .CARKIT_IRQ_FLAG(irq),
        .XCVR_ENABLE(xen), .REG_ENABLE(ren), .DP_PULLUP_ON(pu), .REG_SRC_BATTERY(bat),
        .SIGNAL_MODE(mode), .SE0_ENCODING(se0), .BIDIRECTIONAL(bid));
    ckm_acc_model acc (.clk(clk), .id_sw(idsw), .dm(dm), .dip_go(dgo), .dip_len(dlen), .dp_low(dpl),
        .id_len(idl), .dm_len(dml));
    // Xorshift source and helpers.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One APB transfer; data and error flag are taken at the ready edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pwr, paddr, pwd} <= {1'b1, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = {prd[31:1], prd[0] | serr};
        {psel, pen} <= 2'b00;
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog against a hang.
    initial
    begin
        cyc(20000);
        errors++;
        stop_test();
    end
    // Test sequence.
    initial
    begin
        cyc(10);
        srst <= 1'b0;
        apb(0, ADDR_CTRL, '0);
        chk("ctrl", rd, 32'h0000_0008);
        apb(0, ADDR_MODE, '0);
        chk("mode", rd, 32'h0000_0010);
        apb(0, 8'h0C, '0);
        chk("unmapped", rd, 32'h0000_0001);
        for (int s = 0; s < 3; s++)
        begin
            arst_n <= 1'b0;
            strap <= 2'(s);
            cyc(2);
            arst_n <= 1'b1;
            cyc(PUC + 5);
            chk("strap", {se0, bid}, {s != 2, s != 0});
            chk("power-up", {mode, xen, ren, pu, bat}, 7'h0F);
        end
        apb(1, ADDR_MODE, 32'h0000_0004);
        apb(0, ADDR_MODE, '0);
        chk("mode locked", rd[2:0], '0);
        en <= 1'b0;
        cyc(3);
        chk("pin off", {xen, pu}, '0);
        en <= 1'b1;
        apb(1, ADDR_CTRL, '0);
        cyc(3);
        chk("bit off", xen, '0);
        apb(1, ADDR_CTRL, 32'h0000_0008);
        en <= 1'b0;
        $display("power-up test done");
        apb(1, ADDR_CTRL, 32'h0000_000A);
        cyc(5);
        apb(1, ADDR_CTRL, 32'h0000_000A);
        cyc(IDC + 5);
        apb(0, ADDR_CTRL, '0);
        chk("id_timed_pulse_bit", {idl, rd[15:0]}, {16'(IDC), 16'h0008});
        apb(1, ADDR_CTRL, 32'h0000_0009);
        cyc(IDC + 5);
        chk("id hold", idsw, 1'b1);
        apb(1, ADDR_CTRL, 32'h0000_0008);
        cyc(2);
        chk("id open", idsw, '0);
        apb(1, ADDR_CTRL, 32'h0000_000C);
        cyc(20);
        apb(0, ADDR_CTRL, '0);
        chk("dm pending", {dm, rd[3:0]}, 5'h0C);
        for (int m = 4; m < 6; m++)
        begin
            apb(1, ADDR_MODE, 32'(m));
            apb(1, ADDR_CTRL, 32'h0000_000C);
            cyc(20);
            apb(0, ADDR_CTRL, '0);
            chk("dminus_pulse_request_bit", {dml, rd[3:0]}, {16'(DMINUS_PULSE_REQUEST_BIT_CYC), 4'h8});
        end
        $display("pulse tests done");
        for (int i = 0; i < 12; i++)
        begin
            r = rnd();
            md = (i < 2) ? 3'(4 + i) : r[2:0];
            apb(1, ADDR_MODE, {29'h0, md});
            apb(1, ADDR_STATUS, 32'h0000_0001);
            dlen <= r[3] ? 5'h14 : 5'h08 + 5'(r[6:4]);
            dgo <= 1'b1;
            cyc(1);
            dgo <= 1'b0;
            cyc(25);
            apb(0, ADDR_STATUS, '0);
            chk("carkit flag", rd[0], md[2:1] == 2'b10);
            apb(1, ADDR_STATUS, 32'h0000_0001);
            apb(0, ADDR_STATUS, '0);
            chk("flag clear", rd[1:0], '0);
        end
        $display("carkit test done");
        stop_test();
    end
endmodule // ckm_top_tb_top
`default_nettype wire
